// >>> core/sce_regs.svh
// register offsets, reset values, bit positions and timing of the block
`ifndef SCE_REGS_SVH
`define SCE_REGS_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define SCE_OFF_CTRL  8'h00
`define SCE_OFF_MODE  8'h04
`define SCE_OFF_STAT  8'h08
`define SCE_OFF_TXBUF 8'h0C
`define SCE_OFF_RXBUF 8'h10
`define SCE_OFF_IRQS  8'h14
`define SCE_OFF_IRQM  8'h18
// ----------------------------------------
// reset values
// ----------------------------------------
`define SCE_CTRL_RST  8'h00
`define SCE_MODE_RST  8'h00
`define SCE_STAT_RST  8'h84
`define SCE_TXBUF_RST 8'hFF
`define SCE_IRQ_RST   4'h0
// ----------------------------------------
// control bits
// ----------------------------------------
`define SCE_CT_TXE_IE  7
`define SCE_CT_RXF_IE  6
`define SCE_CT_TX_EN   5
`define SCE_CT_RX_EN   4
`define SCE_CT_AWAIT   3
`define SCE_CT_TXD_IE  2
`define SCE_CT_CLK_EXT 1
`define SCE_CT_CLK_OUT 0
// ----------------------------------------
// mode bits
// ----------------------------------------
`define SCE_MD_SYNC  7
`define SCE_MD_CHR7  6
`define SCE_MD_PAR   5
`define SCE_MD_ODD   4
`define SCE_MD_STOP2 3
`define SCE_MD_MPF   2
`define SCE_MD_CKS   1:0
// ----------------------------------------
// status bits
// ----------------------------------------
`define SCE_ST_TXE  7
`define SCE_ST_RXF  6
`define SCE_ST_OVR  5
`define SCE_ST_FRM  4
`define SCE_ST_PRTY 3
`define SCE_ST_DONE 2
`define SCE_ST_AMRK 1
`define SCE_ST_AMTX 0
// ----------------------------------------
// timing
// ----------------------------------------
`define SCE_BIT_TICKS  4'hF
`define SCE_HALF_TICKS 4'h7
`endif

// >>> core/sce_pkg.sv
// types shared by the serial control block
package sce_pkg;
  typedef enum logic [1:0] {
    SCE_RX_IDLE  = 2'b00,
    SCE_RX_START = 2'b01,
    SCE_RX_BITS  = 2'b11
  } sce_rx_state_t;
endpackage : sce_pkg

// >>> core/sce_serial_control.sv
// serial channel control register, interrupt gating and link logic
// Notes on behaviour
// [RULE1] control register clears on power-on reset or standby, not manual reset
// [RULE2] software may read and write every control bit at any time
// [RULE3] tx empty enable gates the request raised when buffer moves to shifter
// [RULE4] tx empty request drops after read-then-clear of flag or enable off
// [RULE5] rx full enable gates both rx full and rx error requests
// [RULE6] rx requests drop after read-then-clear of flag or enable off
// [RULE7] transmitter off forces and holds tx buffer empty at one
// [RULE8] transmitter on starts sending once empty flag is cleared
// [RULE9] software sets frame format before enabling transmitter or receiver
// [RULE10] receiver off leaves rx full and error flags untouched
// [RULE11] reception starts on start bit or on incoming sync clock edges
// [RULE12] address wait acts only in async mode with multiprocessor format
// [RULE13] address wait discards characters, sets no flags, raises no requests
// [RULE14] address character sets marker, clears address wait, resumes receive
// [RULE15] tx done enable gates request when last bit leaves with buffer empty
// [RULE16] clock bits select clock source and async clock output
// [RULE17] clock output bit matters only in async mode with internal clock
// [RULE18] external async clock runs at sixteen times the bit rate
// [RULE19] each request is a level while its flag and enable are both set
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "sce_regs.svh"
module sce_serial_control #(
  parameter logic [15:0] BAUD_DIV = 16'h0008
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        standby,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        sck_in,
  output logic             txd,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             tx_empty_irq,
  output logic             rx_full_irq,
  output logic             rx_error_irq,
  output logic             tx_done_irq,
  output logic             irq
);
  import sce_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]    ctrl_reg, ctrl_next, mode_reg, txbuf_reg, rxbuf_reg;
  logic [7:3]    flag_reg, flag_next, seen_reg, flag_set, st_clr;
  logic          done_reg, mark_reg, amtx_reg;
  logic [3:0]    irqs_reg, irqs_next, irqm_reg, req_w;
  logic          rxd_m, rxd_s, sck_m, sck_s, sck_d;
  logic [15:0]   baud_cnt;
  logic [3:0]    tick_cnt, tx_left, rx_cnt, rx_sub;
  logic [11:0]   tx_sr, frame, rx_bits;
  logic          tx_busy, rx_done;
  sce_rx_state_t rx_state;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {rxd_m, rxd_s, sck_m, sck_s, sck_d} <= 5'h1F;
    end else begin
      rxd_m <= rxd;
      rxd_s <= rxd_m;
      sck_m <= sck_in;
      sck_s <= sck_m;
      sck_d <= sck_s;
    end
  end
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  wire txe_ie  = ctrl_reg[`SCE_CT_TXE_IE];
  wire rxf_ie  = ctrl_reg[`SCE_CT_RXF_IE];
  wire tx_en   = ctrl_reg[`SCE_CT_TX_EN];
  wire rx_en   = ctrl_reg[`SCE_CT_RX_EN];
  wire txd_ie  = ctrl_reg[`SCE_CT_TXD_IE];
  wire clk_ext = ctrl_reg[`SCE_CT_CLK_EXT];
  wire clk_out = ctrl_reg[`SCE_CT_CLK_OUT];
  wire sync_m  = mode_reg[`SCE_MD_SYNC];
  wire odd_m   = mode_reg[`SCE_MD_ODD];
  wire mpf_on  = mode_reg[`SCE_MD_MPF] & ~sync_m;
  wire par_on  = mode_reg[`SCE_MD_PAR] & ~mpf_on & ~sync_m;
  wire addr_wait = ctrl_reg[`SCE_CT_AWAIT] & mpf_on; // [RULE12]
  wire [3:0] len = (mode_reg[`SCE_MD_CHR7] & ~sync_m) ? 4'h7 : 4'h8;
  wire       extra = mpf_on | par_on;
  wire [7:0] dmask = (len == 4'h7) ? 8'h7F : 8'hFF;
  wire [3:0] tx_n = sync_m ? 4'h8 : 4'(4'h2 + len + {3'h0, extra}
                                     + {3'h0, mode_reg[`SCE_MD_STOP2]});
  wire [3:0] rx_n = sync_m ? 4'h8 : 4'(len + {3'h0, extra} + 4'h1);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire acc      = psel & penable;
  wire xfer     = acc & pready;
  wire wr       = xfer & pwrite;
  wire rd       = xfer & ~pwrite;
  wire sel_ctrl = paddr == `SCE_OFF_CTRL;
  wire sel_mode = paddr == `SCE_OFF_MODE;
  wire sel_stat = paddr == `SCE_OFF_STAT;
  wire sel_txb  = paddr == `SCE_OFF_TXBUF;
  wire sel_rxb  = paddr == `SCE_OFF_RXBUF;
  wire sel_irqs = paddr == `SCE_OFF_IRQS;
  wire sel_irqm = paddr == `SCE_OFF_IRQM;
  wire mapped   = sel_ctrl | sel_mode | sel_stat | sel_txb | sel_rxb
                | sel_irqs | sel_irqm;
  wire wr_ctrl  = wr & sel_ctrl;
  wire wr_stat  = wr & sel_stat;
  wire rd_stat  = rd & sel_stat;
  wire rd_irqs  = rd & sel_irqs;
  wire [7:0] stat_w = {flag_reg, done_reg, mark_reg, amtx_reg};
  wire [7:0] rd_mux = sel_ctrl ? ctrl_reg :                // [RULE2]
                      sel_mode ? mode_reg :
                      sel_stat ? stat_w :
                      sel_txb  ? txbuf_reg :
                      sel_rxb  ? rxbuf_reg :
                      sel_irqs ? {4'h0, irqs_reg} :
                      sel_irqm ? {4'h0, irqm_reg} : 8'h00;

  // one wait state keeps read data a plain register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc & ~pready) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------
  // bit clock
  // ----------------------------------------
  wire [15:0] baud_lim = 16'((BAUD_DIV << {mode_reg[`SCE_MD_CKS], 1'b0})
                             - 16'h0001);
  wire baud_tick = baud_cnt == baud_lim;
  // async external clock is the 16x clock itself
  wire tick    = clk_ext ? (~sync_m & sck_rise) : baud_tick; // [RULE16]
  wire bit_end = tick & (tick_cnt == `SCE_BIT_TICKS);
  wire tx_ev   = (sync_m & clk_ext) ? sck_fall : bit_end;
  wire rx_sev  = clk_ext ? sck_rise : bit_end;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt <= 16'h0000;
      tick_cnt <= 4'h0;
    end else begin
      baud_cnt <= baud_tick ? 16'h0000 : 16'(baud_cnt + 16'h0001);
      if (tick) begin
        tick_cnt <= 4'(tick_cnt + 4'h1);
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  wire ebit = mpf_on ? amtx_reg : (^(txbuf_reg & dmask) ^ odd_m);
  always_comb begin
    frame = 12'hFFF;
    if (sync_m) begin
      frame = {4'hF, txbuf_reg};
    end else begin
      frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < 32'(len)) begin
          frame[i + 1] = txbuf_reg[i];
        end
      end
      if (extra) begin
        frame[len + 4'h1] = ebit;
      end
    end
  end

  wire tx_load = tx_ev & tx_en & ~flag_reg[`SCE_ST_TXE]     // [RULE8]
               & (~tx_busy | (tx_left == 4'h0));
  wire tx_fin  = tx_ev & tx_busy & (tx_left == 4'h0) & ~tx_load;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy <= 1'b0;
      tx_left <= 4'h0;
      tx_sr   <= 12'hFFF;
      txd     <= 1'b1;
    end else if (standby) begin
      tx_busy <= 1'b0;
      txd     <= 1'b1;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_left <= 4'(tx_n - 4'h1);
      tx_sr   <= {1'b1, frame[11:1]};
      txd     <= frame[0];
    end else if (tx_ev & tx_busy) begin
      if (tx_left == 4'h0) begin
        tx_busy <= 1'b0;
        txd     <= 1'b1;
      end else begin
        tx_left <= 4'(tx_left - 4'h1);
        tx_sr   <= {1'b1, tx_sr[11:1]};
        txd     <= tx_sr[0];
      end
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  wire samp = sync_m ? rx_sev : (tick & (rx_sub == `SCE_BIT_TICKS));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= SCE_RX_IDLE;
      rx_cnt   <= 4'h0;
      rx_sub   <= 4'h0;
      rx_bits  <= 12'h000;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_sub <= 4'(rx_sub + 4'h1);
      end
      if (standby | ~rx_en) begin
        rx_state <= SCE_RX_IDLE;
      end else begin
        case (rx_state)
          SCE_RX_IDLE: begin
            rx_cnt <= 4'h0;
            rx_sub <= 4'h0;
            if (sync_m) begin
              rx_state <= SCE_RX_BITS;                         // [RULE11]
            end else if (~rxd_s) begin
              rx_state <= SCE_RX_START;                        // [RULE11]
            end
          end
          SCE_RX_START: begin
            // mid-bit recheck rejects glitches on the line
            if (tick & (rx_sub == `SCE_HALF_TICKS)) begin
              rx_sub   <= 4'h0;
              rx_state <= rxd_s ? SCE_RX_IDLE : SCE_RX_BITS;
            end
          end
          SCE_RX_BITS: begin
            if (samp) begin
              rx_bits[rx_cnt] <= rxd_s;
              rx_cnt <= 4'(rx_cnt + 4'h1);
              if (rx_cnt == 4'(rx_n - 4'h1)) begin
                rx_done  <= 1'b1;
                rx_state <= SCE_RX_IDLE;
              end
            end
          end
          default: begin
            rx_state <= SCE_RX_IDLE;
          end
        endcase
      end
    end
  end

  wire [7:0] rx_data = rx_bits[7:0] & dmask;
  wire rx_ext  = rx_bits[len];
  wire rx_stop = rx_bits[4'(len + {3'h0, extra})];
  wire rx_drop = rx_done & addr_wait & ~rx_ext;             // [RULE13]
  wire rx_take = rx_done & ~rx_drop;
  wire rx_load = rx_take & ~flag_reg[`SCE_ST_RXF];
  wire aw_end  = rx_done & addr_wait & rx_ext;              // [RULE14]

  // ----------------------------------------
  // registers and flags
  // ----------------------------------------
  // rx flags only ever set by receive events, so receiver off keeps them
  assign flag_set = {~tx_en | tx_load,                      // [RULE7]
                     rx_load,                               // [RULE10]
                     rx_take & flag_reg[`SCE_ST_RXF],
                     rx_load & ~sync_m & ~rx_stop,
                     rx_load & par_on & ((^rx_data ^ rx_ext) != odd_m)};
  assign st_clr    = {5{wr_stat}} & ~pwdata[7:3] & seen_reg;  // [RULE4] [RULE6]
  assign flag_next = flag_set | (flag_reg & ~st_clr);
  // software write wins over the automatic address-wait clear
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = pwdata[7:0];                             // [RULE2]
    end else if (aw_end) begin
      ctrl_next[`SCE_CT_AWAIT] = 1'b0;                     // [RULE14]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg  <= `SCE_CTRL_RST;                          // [RULE1]
      mode_reg  <= `SCE_MODE_RST;
      txbuf_reg <= `SCE_TXBUF_RST;
      rxbuf_reg <= 8'h00;
      {flag_reg, done_reg, mark_reg, amtx_reg} <= `SCE_STAT_RST;
      seen_reg  <= 5'h00;
    end else if (standby) begin
      ctrl_reg  <= `SCE_CTRL_RST;                          // [RULE1]
      mode_reg  <= `SCE_MODE_RST;
      txbuf_reg <= `SCE_TXBUF_RST;
      {flag_reg, done_reg, mark_reg, amtx_reg} <= `SCE_STAT_RST;
      seen_reg  <= 5'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      seen_reg <= ((rd_stat ? flag_reg : 5'h00) | seen_reg) & ~st_clr;
      done_reg <= tx_fin | (done_reg & ~st_clr[`SCE_ST_TXE]); // [RULE15]
      if (wr & sel_mode) begin
        mode_reg <= pwdata[7:0];
      end
      if (wr & sel_txb) begin
        txbuf_reg <= pwdata[7:0];
      end
      if (wr_stat) begin
        amtx_reg <= pwdata[`SCE_ST_AMTX];
      end
      if (rx_take & mpf_on) begin
        mark_reg <= rx_ext;                                // [RULE14]
      end
      if (rx_load) begin
        rxbuf_reg <= rx_data;
      end
    end
  end

  // ----------------------------------------
  // interrupts and clock pin
  // ----------------------------------------
  assign req_w = {txe_ie & flag_reg[`SCE_ST_TXE],            // [RULE3]
                  rxf_ie & flag_reg[`SCE_ST_RXF],            // [RULE5]
                  rxf_ie & (|flag_reg[`SCE_ST_OVR:`SCE_ST_PRTY]),
                  txd_ie & done_reg};                        // [RULE15]
  wire [3:0] req_q = {tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq};
  // set beats the read clear so an edge in the read cycle survives
  assign irqs_next = (req_w & ~req_q)
                   | (irqs_reg & ~(rd_irqs ? irqs_reg : 4'h0));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq} <= 4'h0;
      irqs_reg <= `SCE_IRQ_RST;
      irqm_reg <= `SCE_IRQ_RST;
      irq      <= 1'b0;
      sck_oe   <= 1'b0;
      sck_out  <= 1'b1;
    end else begin
      {tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq} <= req_w; // [RULE19]
      irqs_reg <= irqs_next;
      if (wr & sel_irqm) begin
        irqm_reg <= pwdata[3:0];
      end
      // a mask write shows on the line in the same cycle as the new mask
      irq    <= |(irqs_next & ((wr & sel_irqm) ? pwdata[3:0] : irqm_reg));
      sck_oe <= ~clk_ext & (sync_m | clk_out);             // [RULE16] [RULE17]
      // sync clock idles high between characters
      sck_out <= (sync_m & ~tx_busy & (rx_state == SCE_RX_IDLE))
               ? 1'b1 : tick_cnt[3];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  standby_clear_a: assert property (standby |=> ctrl_reg == 8'h00) // [RULE1]
    else $error("control not cleared by standby");
  tx_held_a: assert property (!tx_en |=> flag_reg[7] [*2])  // [RULE7]
    else $error("tx empty not held while transmitter off");
  txe_irq_a: assert property (                              // [RULE3]
    txe_ie && flag_reg[7] |=> tx_empty_irq)
    else $error("tx empty request missing");
  txe_drop_a: assert property (!txe_ie |=> !tx_empty_irq)   // [RULE4]
    else $error("tx empty request not removed");
  rx_irq_a: assert property (rxf_ie && flag_reg[6] |=> rx_full_irq) // [RULE5]
    else $error("rx full request missing");
  rx_drop_a: assert property (                              // [RULE6]
    !rxf_ie |=> !rx_full_irq && !rx_error_irq)
    else $error("rx requests not removed");
  rx_keep_a: assert property (                              // [RULE10]
    !rx_en && rx_state == SCE_RX_IDLE && !wr_stat && !standby
    |=> $stable(flag_reg[6:3]))
    else $error("rx flags changed with receiver off");
  addr_skip_a: assert property (                            // [RULE13]
    rx_drop |=> !$rose(flag_reg[6]) && !$rose(flag_reg[4]))
    else $error("address wait let flags set");
  addr_end_a: assert property (                             // [RULE14]
    aw_end && !wr_ctrl |=> !ctrl_reg[3] && mark_reg)
    else $error("address character not taken");
  tx_start_a: assert property (                             // [RULE8]
    tx_en && !flag_reg[7] && !tx_busy && tx_ev |=> tx_busy && !txd)
    else $error("transmission did not start");
  clk_pin_a: assert property (clk_ext |=> !sck_oe)          // [RULE17]
    else $error("clock driven with external source");
  irq_level_a: assert property (                            // [RULE19]
    |(irqs_reg & irqm_reg) |-> irq)
    else $error("interrupt low with unmasked status");

endmodule : sce_serial_control

// >>> sim/sce_remote.sv
// far-end serial device: drives rxd and sck_in, captures txd
`timescale 1ns/1ps
module sce_remote #(
  parameter int BIT_NS = 160,
  parameter int EXT_NS = 160
) (
  output logic       rxd,
  output logic       sck_in,
  input  wire logic  txd,
  output logic [7:0] got,
  output logic       got_ev
);
  logic ext_run;
  // ----------------------------------------
  // clock stands still outside frames
  // ----------------------------------------
  initial begin
    rxd = 1'b1;
    sck_in = 1'b1;
    ext_run = 1'b0;
  end
  always begin
    if (ext_run) begin
      #(EXT_NS / 2) sck_in = ~sck_in;
    end else begin
      sck_in = 1'b1;
      @(ext_run);
    end
  end
  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  task automatic send(input logic [8:0] chr, input logic has9,
                      input logic stop, input logic ext);
    int bt;
    bt = ext ? 16 * EXT_NS : BIT_NS;
    ext_run = ext;
    #(2 * bt);
    rxd = 1'b0;
    #bt;
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || has9) begin
        rxd = chr[i];
        #bt;
      end
    end
    rxd = stop;
    #bt;
    rxd = 1'b1;
    #(2 * bt);
    ext_run = 1'b0;
  endtask : send
  // ----------------------------------------
  // receiver, mid-bit sampling
  // ----------------------------------------
  initial begin
    got = 8'h00;
    got_ev = 1'b0;
    forever begin
      @(negedge txd);
      #(BIT_NS * 3 / 2);
      for (int i = 0; i < 8; i++) begin
        got[i] = txd;
        #BIT_NS;
      end
      got_ev = ~got_ev;
    end
  end
endmodule : sce_remote

// >>> sim/tb_sce_serial_control.sv
// self-checking bench for the serial control block
`timescale 1ns/1ps
`include "sce_regs.svh"
module tb_sce_serial_control;
  import sce_pkg::*;
  logic        clk_sys, reset_n, standby, psel, penable, pwrite;
  logic [7:0]  paddr, got, d;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, rxd, sck_in, txd, sck_out, sck_oe;
  logic        tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, irq;
  logic        got_ev, ev0;
  int          n_fail, num_checks, cyc;

  sce_serial_control #(.BAUD_DIV(16'h0001)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .standby(standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .sck_in(sck_in), .txd(txd),
    .sck_out(sck_out), .sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq),
    .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
    .tx_done_irq(tx_done_irq), .irq(irq));
  sce_remote rem (.rxd(rxd), .sck_in(sck_in), .txd(txd), .got(got),
    .got_ev(got_ev));
  // ----------------------------------------
  // clock, timeout, report
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // ceiling well above the longest frame sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] bit_of(input logic [31:0] v, input int b);
    bit_of = {31'h0, v[b]};
  endfunction : bit_of
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : pause
  task automatic clr_status;
    apb(0, `SCE_OFF_STAT, 0);
    apb(1, `SCE_OFF_STAT, 0);
  endtask : clr_status
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, standby, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(31813));
    pause(12);
    reset_n <= 1'b1;
    apb(0, `SCE_OFF_CTRL, 0);
    chk("ctrl reset", 32'h00, rd);
    apb(0, `SCE_OFF_STAT, 0);
    chk("status reset", 32'h84, rd);
    apb(0, 8'h1C, 0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      apb(1, `SCE_OFF_CTRL, {24'h0, d});
      apb(0, `SCE_OFF_CTRL, 0);
      chk("ctrl rw", {24'h0, d}, rd);
    end
    apb(1, `SCE_OFF_CTRL, 32'h5A);
    standby <= 1'b1;
    pause(2);
    standby <= 1'b0;
    apb(0, `SCE_OFF_CTRL, 0);
    chk("ctrl standby", 32'h00, rd);
    apb(1, `SCE_OFF_MODE, 32'h00);
    apb(1, `SCE_OFF_IRQM, 32'h4);
    // transmit path
    apb(1, `SCE_OFF_CTRL, 32'hA4);
    pause(3);
    chk("tx empty irq", 32'h1, {31'h0, tx_empty_irq});
    d = 8'($urandom);
    ev0 = got_ev;
    apb(1, `SCE_OFF_TXBUF, {24'h0, d});
    clr_status();
    pause(2);
    chk("tx empty drop", 32'h0, {31'h0, tx_empty_irq});
    for (int n = 0; n < 3000 && got_ev === ev0; n++) pause(1);
    chk("tx byte", {24'h0, d}, {24'h0, got});
    chk("tx empty again", 32'h1, {31'h0, tx_empty_irq});
    for (int n = 0; n < 200 && tx_done_irq !== 1'b1; n++) pause(1);
    chk("tx done irq", 32'h1, {31'h0, tx_done_irq});
    apb(1, `SCE_OFF_CTRL, 32'h24);
    pause(2);
    chk("tx empty off", 32'h0, {31'h0, tx_empty_irq});
    apb(1, `SCE_OFF_CTRL, 32'h00);
    clr_status();
    apb(0, `SCE_OFF_STAT, 0);
    chk("tx empty held", 32'h1, bit_of(rd, `SCE_ST_TXE));
    // receive path, interrupt status and mask
    apb(1, `SCE_OFF_CTRL, 32'h50);
    d = 8'($urandom);
    rem.send({1'b0, d}, 1'b0, 1'b1, 1'b0);
    chk("rx full irq", 32'h1, {31'h0, rx_full_irq});
    chk("irq line", 32'h1, {31'h0, irq});
    apb(0, `SCE_OFF_RXBUF, 0);
    chk("rx byte", {24'h0, d}, rd);
    apb(0, `SCE_OFF_IRQS, 0);
    chk("irq status", 32'h1, bit_of(rd, 2));
    apb(0, `SCE_OFF_IRQS, 0);
    chk("irq status clr", 32'h0, rd);
    pause(2);
    chk("irq line clr", 32'h0, {31'h0, irq});
    clr_status();
    pause(2);
    chk("rx full drop", 32'h0, {31'h0, rx_full_irq});
    rem.send({1'b0, d}, 1'b0, 1'b0, 1'b0);
    chk("rx err irq", 32'h1, {31'h0, rx_error_irq});
    apb(1, `SCE_OFF_CTRL, 32'h40);
    apb(0, `SCE_OFF_STAT, 0);
    chk("framing kept", 32'h1, bit_of(rd, `SCE_ST_FRM));
    apb(1, `SCE_OFF_CTRL, 32'h00);
    pause(2);
    chk("rx err off", 32'h0, {31'h0, rx_error_irq});
    apb(1, `SCE_OFF_STAT, 0);
    // address wait
    apb(1, `SCE_OFF_MODE, 32'h04);
    apb(1, `SCE_OFF_CTRL, 32'h58);
    rem.send({1'b0, d}, 1'b1, 1'b1, 1'b0);
    chk("await irq", 32'h0, {31'h0, rx_full_irq});
    apb(0, `SCE_OFF_STAT, 0);
    chk("await flag", 32'h0, bit_of(rd, `SCE_ST_RXF));
    d = 8'($urandom);
    rem.send({1'b1, d}, 1'b1, 1'b1, 1'b0);
    chk("addr irq", 32'h1, {31'h0, rx_full_irq});
    apb(0, `SCE_OFF_CTRL, 0);
    chk("await cleared", 32'h50, rd);
    apb(0, `SCE_OFF_STAT, 0);
    chk("marker", 32'h1, bit_of(rd, `SCE_ST_AMRK));
    apb(0, `SCE_OFF_RXBUF, 0);
    chk("addr byte", {24'h0, d}, rd);
    clr_status();
    apb(1, `SCE_OFF_MODE, 32'h00);
    apb(1, `SCE_OFF_CTRL, 32'h58);
    rem.send({1'b0, d}, 1'b0, 1'b1, 1'b0);
    chk("await ignored", 32'h1, {31'h0, rx_full_irq});
    apb(0, `SCE_OFF_CTRL, 0);
    chk("await kept", 32'h58, rd);
    clr_status();
    // even parity, wrong parity bit sent
    apb(1, `SCE_OFF_MODE, 32'h20);
    apb(1, `SCE_OFF_CTRL, 32'h50);
    rem.send({~(^d), d}, 1'b1, 1'b1, 1'b0);
    chk("parity irq", 32'h1, {31'h0, rx_error_irq});
    apb(0, `SCE_OFF_STAT, 0);
    chk("parity err", 32'h1, bit_of(rd, `SCE_ST_PRTY));
    clr_status();
    apb(1, `SCE_OFF_MODE, 32'h00);
    // clock source and output
    apb(1, `SCE_OFF_CTRL, 32'h01);
    pause(3);
    chk("sck out on", 32'h1, {31'h0, sck_oe});
    apb(1, `SCE_OFF_CTRL, 32'h03);
    pause(3);
    chk("sck out ext", 32'h0, {31'h0, sck_oe});
    apb(1, `SCE_OFF_CTRL, 32'h12);
    d = 8'($urandom);
    rem.send({1'b0, d}, 1'b0, 1'b1, 1'b1);
    apb(0, `SCE_OFF_RXBUF, 0);
    chk("ext clk byte", {24'h0, d}, rd);
    final_report();
  end
endmodule : tb_sce_serial_control
